// ---- src/rcl_top.sv ----
// mode decode, strap capture, power-down and eeprom load control
`timescale 1ns/1ps
`default_nettype none

module rcl_top
    import rcl_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // board pins, asynchronous
    input  wire logic [2:0]  i_mode_lvl,
    input  wire rcl_strap_t  i_strap_lvl,
    input  wire logic        i_bank0_power_down,
    input  wire logic        i_bank1_power_down,
    input  wire logic        i_read_en_n,
    // eeprom primary engine, same clock
    output logic             o_ee_start,
    input  wire logic        i_ee_done,
    input  wire logic        i_ee_ok,
    // load-done open-drain pin
    output logic             o_done_n_o,
    output logic             o_done_n_oe,
    // configuration to the datapath
    output rcl_strap_t       o_strap_cfg,
    output logic             o_strap_mode,
    output logic             o_sec_en,
    output logic [5:0]       o_sec_addr_sel,
    output logic [1:0]       o_bank_pd,
    output logic [1:0]       o_rxdet_restart,
    output logic [1:0]       o_lane_en,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        // synchroniser stages, first and second flop of each pin, plus a third delay flop (pd_d, ren_d) for edge detect
        logic [2:0]       mode_s1;
        logic [2:0]       mode_s2;
        rcl_strap_t       strap_s1;
        rcl_strap_t       strap_s2;
        logic [1:0]       pd_s1;
        logic [1:0]       pd_s2;
        logic [1:0]       pd_d;
        logic             ren_s1;
        logic             ren_s2;
        logic             ren_d;
        // power-up capture
        logic [PWR_W-1:0] pwr_cnt;
        logic             cap;
        rcl_strap_t       strap;
        // load control and software bits
        rcl_ld_t          ld;
        logic [1:0]       ctrl;
        // registered outputs
        logic             ee_start;
        logic             done_oe;
        logic             strap_mode;
        logic             sec_en;
        logic [5:0]       addr_sel;
        rcl_strap_t       cfg;
        logic [1:0]       bank_pd;
        logic [1:0]       rxdet;
        logic [1:0]       lane_en;
        // bus data phase and answer
        logic             dp_wr;
        logic [7:0]       dp_addr;
        logic [31:0]      rdata;
        logic             rdy;
        logic             err;
    } rcl_state_t;

    rcl_state_t s_r;
    rcl_state_t s_nxt;

    // register word offset decode, shared by read and write
    function automatic logic [7:0] reg_ofs(input logic [31:0] a);
        reg_ofs = {a[7:2], 2'b00};
    endfunction

    // only whole-word nonseq/seq transfers are acted on
    function automatic logic xfer_ok(input logic [1:0] t, input logic [2:0] sz);
        xfer_ok = t[1] && (sz == 3'h2);
    endfunction

    logic        mode_l0;
    logic        mode_l1;
    logic        mode_l2;
    logic        ren_fall;
    logic        ren_low;
    logic        load_run;
    logic [31:0] status_w;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        s_nxt = s_r;

        // two-flop synchronisers for every board pin
        s_nxt.mode_s1  = i_mode_lvl;
        s_nxt.mode_s2  = s_r.mode_s1;
        s_nxt.strap_s1 = i_strap_lvl;
        s_nxt.strap_s2 = s_r.strap_s1;
        s_nxt.pd_s1    = {i_bank1_power_down, i_bank0_power_down};
        s_nxt.pd_s2    = s_r.pd_s1;
        s_nxt.pd_d     = s_r.pd_s2;
        s_nxt.ren_s1   = i_read_en_n;
        s_nxt.ren_s2   = s_r.ren_s1;
        s_nxt.ren_d    = s_r.ren_s2;

        // mode is decoded live, so a change after power-up takes effect
        mode_l0 = (s_r.mode_s2 == LVL_L0);
        mode_l1 = (s_r.mode_s2 == LVL_L1);
        mode_l2 = (s_r.mode_s2 == LVL_L2);

        // power-up settle, then straps are caught exactly once
        if (!s_r.cap) begin
            if (s_r.pwr_cnt == PWR_W'(PWRUP_CYC - 1)) begin
                s_nxt.cap   = 1'b1;
                s_nxt.strap = s_r.strap_s2;
            end else begin
                s_nxt.pwr_cnt = s_r.pwr_cnt + PWR_W'(1);
            end
        end
        // once cap is set nothing rewrites strap until reset

        // read-enable only matters in the eeprom primary mode
        ren_low  = mode_l1 && !s_r.ren_s2;
        ren_fall = mode_l1 && s_r.ren_d && !s_r.ren_s2;

        // load sequencer
        s_nxt.ee_start = 1'b0;
        if (!mode_l1) begin
            s_nxt.ld = LD_OFF;
        end else begin
            case (s_r.ld)
                LD_OFF: begin
                    // entering the eeprom mode arms the fetch
                    s_nxt.ld = LD_WAIT;
                end
                LD_WAIT: begin
                    // start only after power-up has completed
                    if (s_r.cap && ren_low) begin
                        s_nxt.ld       = LD_BUSY;
                        s_nxt.ee_start = 1'b1;
                    end
                end
                LD_BUSY: begin
                    // the engine reports done and its verdict together
                    if (i_ee_done) begin
                        s_nxt.ld = i_ee_ok ? LD_OK : LD_FAIL;
                    end
                end
                LD_OK: begin
                    // read-enable may stay low; no reload is triggered
                    s_nxt.ld = LD_OK;
                end
                LD_FAIL: begin
                    // retry on a fresh low pulse or by software
                    if (ren_fall || s_r.ctrl[CTRL_RETRY_BIT]) begin
                        s_nxt.ld       = LD_BUSY;
                        s_nxt.ee_start = 1'b1;
                    end
                end
                default: begin
                    s_nxt.ld = LD_OFF;
                end
            endcase
        end
        // lanes go dark from the start edge until the engine answers
        load_run = (s_nxt.ld == LD_BUSY);

        // done pin: pulled low only after a good load, else released
        s_nxt.done_oe = mode_l1 && (s_nxt.ld == LD_OK);

        // configuration source per mode
        s_nxt.strap_mode = mode_l0 && s_r.cap;
        s_nxt.sec_en     = mode_l1 || mode_l2;
        // arbitration with other primaries lives in the bus engine
        // a source that is not selected reads as zero
        s_nxt.cfg        = STRAP_RST;
        s_nxt.addr_sel   = 6'h00;
        if (mode_l0 && s_r.cap) begin
            s_nxt.cfg = s_r.strap;
        end else if ((mode_l1 || mode_l2) && s_r.cap) begin
            // shared pins now give the address; gain pin is bus data
            s_nxt.addr_sel = {s_r.strap.b0_boost_a, s_r.strap.b0_boost_b};
        end
        // test levels L3/L4 leave every source off

        // bank power-down, live in every mode
        s_nxt.bank_pd = s_r.pd_s2;
        // any edge restarts receiver detect for that bank
        s_nxt.rxdet   = s_r.pd_s2 ^ s_r.pd_d;

        // lanes pass data only when powered, configured and not loading
        for (int b = 0; b < 2; b++) begin
            s_nxt.lane_en[b] = !s_r.pd_s2[b] && s_r.cap && !load_run
                               && !s_r.ctrl[CTRL_MUTE_BIT];
        end

        // retry request is a self-clearing command bit
        // a write of the same bit in this cycle still wins below
        if (s_r.ctrl[CTRL_RETRY_BIT]) begin
            s_nxt.ctrl[CTRL_RETRY_BIT] = 1'b0;
        end

        // ahb data phase: apply a pending write
        if (s_r.dp_wr && s_r.dp_addr == ADDR_CTRL) begin
            s_nxt.ctrl = hwdata[1:0];
        end

        // status word
        status_w = 32'h0;
        status_w[ST_MODE_LSB +: 3] = s_r.mode_s2;
        status_w[ST_LD_LSB +: 3]   = s_r.ld;
        status_w[ST_PD_LSB +: 2]   = s_r.pd_s2;
        status_w[ST_CAP_BIT]       = s_r.cap;
        status_w[ST_RSVD_BIT]      = !(mode_l0 || mode_l1 || mode_l2);
        status_w[ST_LANE_LSB +: 2] = s_r.lane_en;

        // no wait states and no error: every register answers at once
        s_nxt.rdy = 1'b1;
        s_nxt.err = 1'b0;

        // ahb address phase: decode and prepare read data
        // taken only with hready high, so a stalled bus never doubles a request
        s_nxt.dp_wr = 1'b0;
        if (hsel && hready && xfer_ok(htrans, hsize)) begin
            s_nxt.dp_wr   = hwrite;
            s_nxt.dp_addr = reg_ofs(haddr);
            if (!hwrite) begin
                case (reg_ofs(haddr))
                    ADDR_STATUS: s_nxt.rdata = status_w;
                    ADDR_STRAP:  s_nxt.rdata = {14'h0, s_r.strap};
                    ADDR_CTRL:   s_nxt.rdata = {30'h0, s_r.ctrl};
                    default:     s_nxt.rdata = 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // all state resets to constants; straps are caught later by the counter
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r            <= '0;
            s_r.mode_s1    <= LVL_L0;
            s_r.mode_s2    <= LVL_L0;
            s_r.strap      <= STRAP_RST;
            s_r.ld         <= LD_OFF;
            s_r.ctrl       <= CTRL_RST;
            // pins idle low through their pull-downs; edge detectors start there
            s_r.pd_s1      <= 2'h0;
            s_r.pd_s2      <= 2'h0;
            s_r.pd_d       <= 2'h0;
            s_r.bank_pd    <= 2'h3;
            s_r.ren_s1     <= 1'b0;
            s_r.ren_s2     <= 1'b0;
            s_r.ren_d      <= 1'b0;
            s_r.rdy        <= 1'b1;
            s_r.dp_addr    <= 8'h00;
            s_r.rdata      <= 32'h0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop except the constant o_done_n_o

    assign o_ee_start      = s_r.ee_start;
    assign o_done_n_o      = 1'b0;  // open drain: only ever pulls low
    assign o_done_n_oe     = s_r.done_oe;
    assign o_strap_cfg     = s_r.cfg;
    assign o_strap_mode    = s_r.strap_mode;
    assign o_sec_en        = s_r.sec_en;
    assign o_sec_addr_sel  = s_r.addr_sel;
    assign o_bank_pd       = s_r.bank_pd;
    assign o_rxdet_restart = s_r.rxdet;
    assign o_lane_en       = s_r.lane_en;
    assign hrdata          = s_r.rdata;
    // zero wait states, always okay: nothing here can stall
    assign hreadyout       = s_r.rdy;
    assign hresp           = s_r.err;

endmodule

`default_nettype wire

// ---- common/rcl_pkg.sv ----
// constants, types and layouts of the redriver configuration control block
// Notes on behaviour
// - level L0: all settings from straps only
// - level L1: fetch EEPROM, drive done low
// - level L1: secondary bus answers at all times
// - level L2: secondary only, external primary configures
// - mode pin honoured at power-up and later
// - strap mode: bank0 boost straps, power-up
// - bus modes: shared straps give secondary address
// - strap mode: bank1 boost straps, power-up
// - strap mode: bank0 gain strap; else data
// - strap mode: bank1 gain strap, power-up
// - bank0 power-down high powers channels 0-3 down
// - bank1 power-down high powers channels 4-7 down
// - power-down toggle restarts receiver detect
// - L1 after power-up: read-enable low starts fetch
// - signal path disabled while load runs
// - read-enable ignored outside L1
// - done high if incomplete; high-Z outside L1
package rcl_pkg;

    // five-level pin codes
    localparam logic [2:0] LVL_L0 = 3'h0;
    localparam logic [2:0] LVL_L1 = 3'h1;
    localparam logic [2:0] LVL_L2 = 3'h2;
    localparam logic [2:0] LVL_L3 = 3'h3;
    localparam logic [2:0] LVL_L4 = 3'h4;

    // register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_STRAP  = 8'h04;
    localparam logic [7:0] ADDR_CTRL   = 8'h08;

    // control register fields and reset value
    localparam int         CTRL_RETRY_BIT = 0;
    localparam int         CTRL_MUTE_BIT  = 1;
    localparam logic [1:0] CTRL_RST       = 2'h0;

    // status register field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_LD_LSB   = 4;
    localparam int ST_PD_LSB   = 8;
    localparam int ST_CAP_BIT  = 10;
    localparam int ST_RSVD_BIT = 11;
    localparam int ST_LANE_LSB = 12;

    // power-up settle time before straps are sampled
    localparam int PWRUP_NS  = 1000;
    localparam int CLK_MHZ   = 125;
    localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PWR_W     = $clog2(PWRUP_CYC + 1);

    // eeprom load sequencer
    typedef enum logic [2:0] {
        LD_OFF  = 3'b000,
        LD_WAIT = 3'b001,
        LD_BUSY = 3'b010,
        LD_OK   = 3'b011,
        LD_FAIL = 3'b100
    } rcl_ld_t;

    // strap levels, one five-level code each
    typedef struct packed {
        logic [2:0] b0_boost_a;
        logic [2:0] b0_boost_b;
        logic [2:0] b1_boost_a;
        logic [2:0] b1_boost_b;
        logic [2:0] b0_gain;
        logic [2:0] b1_gain;
    } rcl_strap_t;

    localparam rcl_strap_t STRAP_RST = '0;

endpackage

// ---- tb/rcl_assertions.sv ----
// checker for the configuration control block
`timescale 1ns/1ps
`default_nettype none
module rcl_assertions
    import rcl_pkg::*;
(
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rstn,
    // watched ports
    input wire logic       i_bank0_power_down,
    input wire logic       i_bank1_power_down,
    input wire logic       o_ee_start,
    input wire logic       i_ee_done,
    input wire logic       i_ee_ok,
    input wire logic       o_done_n_o,
    input wire logic       o_done_n_oe,
    input wire rcl_strap_t o_strap_cfg,
    input wire logic       o_strap_mode,
    input wire logic       o_sec_en,
    input wire logic [5:0] o_sec_addr_sel,
    input wire logic [1:0] o_bank_pd,
    input wire logic [1:0] o_rxdet_restart,
    input wire logic [1:0] o_lane_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    ////////////////////////////////
    // edges since reset; sync pipes hold stale levels early on
    logic [3:0] cyc_r;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) cyc_r <= 4'h0;
        else if (cyc_r != 4'hf) cyc_r <= cyc_r + 4'h1;
    end
    sequence s_quiet; ($stable(i_bank0_power_down) && $stable(i_bank1_power_down)) [*4]; endsequence
    sequence s_off; (o_lane_en == 2'h0) [*2]; endsequence
    ////////////////////////////////
    property p_done_src; $rose(o_done_n_oe) |-> $past(i_ee_done && i_ee_ok); endproperty
    a_done_src: assert property (p_done_src) else $error("done without good load");
    property p_done_pin; o_done_n_oe |-> o_sec_en && !o_done_n_o; endproperty
    a_done_pin: assert property (p_done_pin) else $error("done pin wrong");
    property p_start; o_ee_start |-> o_sec_en && !o_done_n_oe ##1 !o_ee_start; endproperty
    a_start: assert property (p_start) else $error("bad fetch start");
    property p_mute; o_ee_start |-> s_off; endproperty
    a_mute: assert property (p_mute) else $error("lanes on in load");
    property p_pd_lane; (o_lane_en & o_bank_pd) == 2'h0; endproperty
    a_pd_lane: assert property (p_pd_lane) else $error("lane on while down");
    property p_pd; (cyc_r == 4'hf) ##0 s_quiet |-> o_bank_pd == {i_bank1_power_down, i_bank0_power_down};
    endproperty
    a_pd: assert property (p_pd) else $error("pd not followed");
    property p_rx; (cyc_r == 4'hf) && $changed(i_bank0_power_down) |-> ##[1:5] o_rxdet_restart[0]; endproperty
    a_rx: assert property (p_rx) else $error("no rx restart");
    property p_strap; o_strap_mode |-> !o_sec_en && o_sec_addr_sel == 6'h00 && !o_done_n_oe; endproperty
    a_strap: assert property (p_strap) else $error("bus used in strap mode");
    property p_hold; o_strap_mode && $past(o_strap_mode) |-> $stable(o_strap_cfg); endproperty
    a_hold: assert property (p_hold) else $error("straps changed");
    property p_addr; o_sec_en && o_sec_addr_sel != 6'h00 && $past(o_sec_addr_sel) != 6'h00 |-> $stable(o_sec_addr_sel);
    endproperty
    a_addr: assert property (p_addr) else $error("address changed");
endmodule
bind rcl_top rcl_assertions u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_bank0_power_down(i_bank0_power_down),
    .i_bank1_power_down(i_bank1_power_down), .o_ee_start(o_ee_start), .i_ee_done(i_ee_done), .i_ee_ok(i_ee_ok),
    .o_done_n_o(o_done_n_o), .o_done_n_oe(o_done_n_oe), .o_strap_cfg(o_strap_cfg), .o_strap_mode(o_strap_mode),
    .o_sec_en(o_sec_en), .o_sec_addr_sel(o_sec_addr_sel), .o_bank_pd(o_bank_pd),
    .o_rxdet_restart(o_rxdet_restart), .o_lane_en(o_lane_en));
`default_nettype wire

// ---- tb/rcl_ee_model.sv ----
// eeprom fetch engine standing at the far side
`timescale 1ns/1ps
`default_nettype none
module rcl_ee_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // request and knobs
    input  wire logic       i_start,
    input  wire logic       i_pass,
    input  wire logic [3:0] i_dly,
    // result
    output logic            o_done,
    output logic            o_ok
);
    logic       busy_r;
    logic [3:0] cnt_r;
    // sole primary here, so no arbitration needed
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_r <= 1'b0;
            cnt_r  <= 4'h0;
        end else if (i_start) begin
            busy_r <= 1'b1;
            cnt_r  <= i_dly;
        end else if (busy_r) begin
            busy_r <= cnt_r != 4'h0;
            cnt_r  <= cnt_r - 4'h1;
        end
    end
    // result only with done; inverse otherwise, so a stale o_ok always disagrees with i_pass
    assign o_done = busy_r && cnt_r == 4'h0;
    assign o_ok   = o_done ? i_pass : ~i_pass;
endmodule
`default_nettype wire

// ---- tb/rcl_top_tb_top.sv ----
// self-checking bench for the configuration control block
`timescale 1ns/1ps
`default_nettype none
module rcl_top_tb_top
    import rcl_pkg::*;
;
    localparam rcl_strap_t SP1 = {3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h2};
    localparam rcl_strap_t SP2 = {3'h4, 3'h3, 3'h0, 3'h1, 3'h2, 3'h0};
    // inputs, all set at time zero
    logic        i_clk = 1'b0, i_rstn = 1'b0, pd0 = 1'b0, pd1 = 1'b0, rd_en_n = 1'b1;
    logic        hwrite = 1'b0, ee_pass = 1'b0;
    logic [2:0]  mode = LVL_L0, hsize = 3'h2;
    rcl_strap_t  strap = SP1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [3:0]  ee_dly = 4'h1;
    // outputs
    wire         ee_start, ee_done, ee_ok, done_o, done_oe, strap_mode, sec_en, hrdy, hresp;
    wire rcl_strap_t strap_cfg;
    wire [5:0]   sec_addr;
    wire [1:0]   bank_pd, rxdet, lane_en;
    wire [31:0]  hrdata;
    int          fail_count = 0, tests_run = 0, cyc = 0, starts = 0, rxc [2] = '{0, 0};

    always #4 i_clk = ~i_clk;
    rcl_top DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_mode_lvl(mode), .i_strap_lvl(strap),
        .i_bank0_power_down(pd0), .i_bank1_power_down(pd1), .i_read_en_n(rd_en_n), .o_ee_start(ee_start),
        .i_ee_done(ee_done), .i_ee_ok(ee_ok), .o_done_n_o(done_o), .o_done_n_oe(done_oe), .o_strap_cfg(strap_cfg),
        .o_strap_mode(strap_mode), .o_sec_en(sec_en), .o_sec_addr_sel(sec_addr), .o_bank_pd(bank_pd),
        .o_rxdet_restart(rxdet), .o_lane_en(lane_en), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp));
    rcl_ee_model EE (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(ee_start), .i_pass(ee_pass), .i_dly(ee_dly),
        .o_done(ee_done), .o_ok(ee_ok));
    // tallies by nba so same-edge reads never race
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        starts <= starts + ee_start;
        rxc[0] <= rxc[0] + rxdet[0];
        rxc[1] <= rxc[1] + rxdet[1];
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    ////////////////////////////////
    task automatic chk(input string n, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    // single word transfer, waits on the slave's ready
    task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge i_clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hrdy !== 1'b1);
        d = hrdata;
    endtask
    task automatic rst(input logic [2:0] m);
        i_rstn <= 1'b0;
        mode <= m;
        strap <= SP1;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (PWRUP_CYC + 6) @(posedge i_clk);
    endtask
    task automatic t_strap();
        rst(LVL_L0);
        chk("strap_mode", strap_mode, 1);
        chk("strap_cfg", strap_cfg, SP1);
        chk("bus_off", {sec_en, sec_addr}, 0);
        strap <= SP2;
        rd_en_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        chk("cfg_hold", strap_cfg, SP1);
        chk("no_load", {starts[7:0], done_oe}, 0);
        ahb(1'b0, ADDR_STRAP, 0, rd);
        chk("strap_reg", rd, SP1);
        ahb(1'b0, 32'h40, 0, rd);
        chk("unmapped", rd, 0);
        ahb(1'b1, ADDR_CTRL, 32'h2, rd);
        repeat (3) @(posedge i_clk);
        chk("mute", lane_en, 0);
        ahb(1'b1, ADDR_CTRL, 32'h0, rd);
        rd_en_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("lanes", lane_en, 3);
    endtask
    task automatic t_pd();
        for (int b = 0; b < 2; b++) begin
            int n = rxc[b];
            if (b == 0) pd0 <= 1'b1;
            else pd1 <= 1'b1;
            repeat (8) @(posedge i_clk);
            chk("pd_on", {bank_pd, lane_en}, b ? 4'h9 : 4'h6);
            chk("rx_on", rxc[b] - n, 1);
            pd0 <= 1'b0;
            pd1 <= 1'b0;
            repeat (8) @(posedge i_clk);
            chk("rx_off", rxc[b] - n, 2);
        end
    endtask
    task automatic t_load();
        rst(LVL_L1);
        chk("sec", {sec_en, strap_mode, sec_addr}, {2'b10, 6'h0a});
        chk("cfg_off", strap_cfg, 0);
        rd_en_n <= 1'b0;
        for (int i = 0; i < 20 && ee_start !== 1'b1; i++) @(posedge i_clk);
        chk("lanes_off", {starts[7:0], lane_en}, 0);
        repeat (8) @(posedge i_clk);
        ahb(1'b0, ADDR_STATUS, 0, rd);
        chk("failed", {done_oe, rd[6:4]}, 4'h4);
        chk("bus_resp", {hresp, hrdy}, 2'b01);
        rd_en_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd_en_n <= 1'b0;
        repeat (12) @(posedge i_clk);
        chk("ren_retry", starts, 2);
        ee_pass <= 1'b1;
        ee_dly <= 4'h9;
        ahb(1'b1, ADDR_CTRL, 32'h1, rd);
        for (int i = 0; i < 40 && done_oe !== 1'b1; i++) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        chk("done", {done_oe, done_o, lane_en}, 4'hb);
        repeat (10) @(posedge i_clk);
        chk("held", {starts[7:0], done_oe}, 9'h007);
        mode <= LVL_L2;
        repeat (6) @(posedge i_clk);
        chk("l2", {done_oe, sec_en, sec_addr}, {2'b01, 6'h0a});
        mode <= LVL_L0;
        repeat (6) @(posedge i_clk);
        chk("l0", {strap_mode, sec_en}, 2'b10);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        t_strap();
        t_pd();
        t_load();
        give_verdict();
    end
endmodule
`default_nettype wire
